// >>> src/osdc_defines.vh
// Purpose: constants for the display control and vertical origin block
// Assumes: 8-bit special function register port, 200 MHz mclk
// Notes: offsets are the printed register addresses
`ifndef OSDC_DEFINES_VH
`define OSDC_DEFINES_VH
`define OSDC_ADDR_DEFAULTS 8'h9c
`define OSDC_ADDR_CONTROL 8'hc1
`define OSDC_ADDR_ORIGIN 8'hc2
`define OSDC_DEFAULTS_RESET 8'h22
`define OSDC_DEFAULTS_MASK 8'hef
`define OSDC_CONTROL_RESET 8'h00
`define OSDC_ORIGIN_RESET 8'h01
`define OSDC_ORIGIN_MASK 8'h3f
`define OSDC_BIT_SPLIT 7
`define OSDC_BIT_MESH 6
`define OSDC_BIT_FRAME 5
`define OSDC_BIT_HPOL 4
`define OSDC_BIT_VPOL 3
`define OSDC_BIT_OPOL 2
`define OSDC_BIT_BLINK 1
`define OSDC_BIT_EN 0
`define OSDC_BLINK_HALF_SLOW 6'h1f
`define OSDC_BLINK_HALF_FAST 6'h0f
`define OSDC_ORIGIN_STEP 2
`define OSDC_SYNC_IDLE 2'h3
`endif

// >>> src/osdc_control.v
// Purpose: display control, frame defaults and vertical origin logic
// Assumes: syncs are asynchronous pins; register port is synchronous
// Notes: character fetch supplies char_on, space/return codes
`timescale 1ns/100ps
`default_nettype none
`include "osdc_defines.vh"
module osdc_control (
	input wire mclk,
	input wire rstn,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	output reg [7:0] sfr_rdata,
	input wire hsync_pin,
	input wire vsync_pin,
	input wire char_on,
	input wire [2:0] char_rgb,
	input wire lead_code_valid,
	input wire [7:0] lead_code_defaults,
	input wire space_first,
	output reg [2:0] work_colour,
	output reg dot_height_double,
	output reg dot_width_double,
	output reg [1:0] work_submode,
	output wire split_space_en,
	output wire space_transparent,
	output wire mesh_en,
	output wire blink_phase,
	output wire display_window,
	output wire hsync_corrected,
	output wire vsync_corrected,
	output reg [2:0] rgb_out,
	output reg fast_blanking_out
);
	reg [7:0] display_frame_defaults_reg;
	reg [7:0] display_main_control_reg;
	reg [7:0] display_vertical_origin_reg;
	reg [1:0] hs_sync_reg;
	reg [1:0] vs_sync_reg;
	reg hs_prev_reg;
	reg vs_prev_reg;
	reg [7:0] line_count_reg;
	reg [5:0] blink_count_reg;
	reg blink_reg;
	reg window_reg;
	reg rgb_on;
	reg fb_on;
	wire hs_rise;
	wire vs_rise;
	wire [7:0] start_line;
	wire [5:0] blink_half;
	wire wr_defaults;
	wire wr_control;
	wire wr_origin;
	reg [7:0] display_frame_defaults_next;
	reg [7:0] display_main_control_next;
	reg [7:0] display_vertical_origin_next;
	reg [7:0] load_value;
	reg load_en;
	reg [7:0] line_count_next;
	reg window_next;
	reg [5:0] blink_count_next;
	reg blink_next;
	reg [2:0] rgb_next;
	reg fb_next;

	// write strobe aimed at one register address
	function reg_hit;
		input strobe;
		input [7:0] addr;
		input [7:0] target;
	begin
		reg_hit = strobe && (addr == target);
	end
	endfunction

	// raw sync pin to active-high form
	function sync_fix;
		input pin;
		input active_high;
	begin
		sync_fix = pin ~^ active_high;
	end
	endfunction

	// active-high levels to pin levels under the output polarity bit
	function [3:0] pin_level;
		input [3:0] active;
		input active_high;
	begin
		pin_level = active ^ {4{~active_high}};
	end
	endfunction

	// read value of one register address, zero where unmapped
	function [7:0] read_value;
		input [7:0] addr;
		input [7:0] defaults_value;
		input [7:0] control_value;
		input [7:0] origin_value;
	begin
		case (addr)
			`OSDC_ADDR_DEFAULTS: read_value = defaults_value;
			`OSDC_ADDR_CONTROL: read_value = control_value;
			`OSDC_ADDR_ORIGIN: read_value = origin_value;
			default: read_value = 8'h00;
		endcase
	end
	endfunction

	assign hsync_corrected = sync_fix(hs_sync_reg[1],
		display_main_control_reg[`OSDC_BIT_HPOL]);
	assign vsync_corrected = sync_fix(vs_sync_reg[1],
		display_main_control_reg[`OSDC_BIT_VPOL]);
	assign wr_defaults = reg_hit(sfr_wr, sfr_addr, `OSDC_ADDR_DEFAULTS);
	assign wr_control = reg_hit(sfr_wr, sfr_addr, `OSDC_ADDR_CONTROL);
	assign wr_origin = reg_hit(sfr_wr, sfr_addr, `OSDC_ADDR_ORIGIN);
	assign hs_rise = hsync_corrected & ~hs_prev_reg;
	assign vs_rise = vsync_corrected & ~vs_prev_reg;
	assign split_space_en = display_main_control_reg[`OSDC_BIT_SPLIT];
	assign space_transparent = ~space_first;
	assign mesh_en = display_main_control_reg[`OSDC_BIT_MESH];
	assign blink_phase = blink_reg;
	assign display_window = window_reg;
	// four lines per origin step
	assign start_line = {display_vertical_origin_reg[5:0], 2'b00};
	assign blink_half = display_main_control_reg[`OSDC_BIT_BLINK] ?
		`OSDC_BLINK_HALF_SLOW : `OSDC_BLINK_HALF_FAST;

	// two-stage synchronisers and edge history of the corrected syncs
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			// idle level of an active-low pin, so no false edge
			hs_sync_reg <= `OSDC_SYNC_IDLE;
			hs_prev_reg <= 1'b0;
		end
		else
		begin
			hs_sync_reg <= {hs_sync_reg[0], hsync_pin};
			hs_prev_reg <= hsync_corrected;
		end
	end

	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			vs_sync_reg <= `OSDC_SYNC_IDLE;
			vs_prev_reg <= 1'b0;
		end
		else
		begin
			vs_sync_reg <= {vs_sync_reg[0], vsync_pin};
			vs_prev_reg <= vsync_corrected;
		end
	end

	// register port; reserved bits are never stored
	always @*
	begin
		display_frame_defaults_next = display_frame_defaults_reg;
		display_main_control_next = display_main_control_reg;
		display_vertical_origin_next = display_vertical_origin_reg;
		if (wr_defaults)
			display_frame_defaults_next = sfr_wdata &
				`OSDC_DEFAULTS_MASK;
		if (wr_control)
			display_main_control_next = sfr_wdata;
		if (wr_origin)
			display_vertical_origin_next = sfr_wdata &
				`OSDC_ORIGIN_MASK;
	end

	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			display_frame_defaults_reg <= `OSDC_DEFAULTS_RESET;
			display_main_control_reg <= `OSDC_CONTROL_RESET;
			display_vertical_origin_reg <= `OSDC_ORIGIN_RESET;
		end
		else
		begin
			display_frame_defaults_reg <= display_frame_defaults_next;
			display_main_control_reg <= display_main_control_next;
			display_vertical_origin_reg <= display_vertical_origin_next;
		end
	end

	always @*
	begin
		sfr_rdata = read_value(sfr_addr, display_frame_defaults_reg,
			display_main_control_reg, display_vertical_origin_reg);
	end

	// working defaults: write beats frame reload beats lead code
	always @*
	begin
		load_value = display_frame_defaults_reg;
		load_en = 1'b0;
		if (wr_defaults)
		begin
			load_value = sfr_wdata;
			load_en = 1'b1;
		end
		else if (vs_rise)
		begin
			load_value = display_frame_defaults_reg;
			load_en = 1'b1;
		end
		else if (lead_code_valid)
		begin
			load_value = lead_code_defaults;
			load_en = 1'b1;
		end
	end

	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			work_colour <= 3'h1;
			dot_height_double <= 1'b0;
			dot_width_double <= 1'b0;
			work_submode <= 2'h2;
		end
		else if (load_en)
		begin
			work_colour <= load_value[7:5];
			dot_height_double <= load_value[3];
			dot_width_double <= load_value[2];
			work_submode <= load_value[1:0];
		end
	end

	// line counter, origin window, blink
	always @*
	begin
		line_count_next = line_count_reg;
		window_next = window_reg;
		blink_count_next = blink_count_reg;
		blink_next = blink_reg;
		if (vs_rise)
		begin
			line_count_next = 8'h00;
			window_next = 1'b0;
			if (blink_count_reg >= blink_half)
			begin
				blink_count_next = 6'h00;
				blink_next = ~blink_reg;
			end
			else
				blink_count_next = blink_count_reg + 6'h01;
		end
		else if (hs_rise)
		begin
			if (line_count_reg != 8'hff)
				line_count_next = line_count_reg + 8'h01;
			if (line_count_reg + 8'h01 == start_line)
				window_next = 1'b1;
		end
	end

	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			line_count_reg <= 8'h00;
			window_reg <= 1'b0;
			blink_count_reg <= 6'h00;
			blink_reg <= 1'b0;
		end
		else
		begin
			line_count_reg <= line_count_next;
			window_reg <= window_next;
			blink_count_reg <= blink_count_next;
			blink_reg <= blink_next;
		end
	end

	// output polarity and blanking
	always @*
	begin
		rgb_on = window_reg & char_on;
		if (display_main_control_reg[`OSDC_BIT_FRAME])
			fb_on = window_reg & ~hsync_corrected &
				~vsync_corrected;
		else
			fb_on = window_reg & char_on;
		if (!display_main_control_reg[`OSDC_BIT_EN])
		begin
			rgb_on = 1'b0;
			fb_on = 1'b0;
		end
		{rgb_next, fb_next} = pin_level({(rgb_on ? char_rgb : 3'h0), fb_on},
			display_main_control_reg[`OSDC_BIT_OPOL]);
	end

	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rgb_out <= 3'h7;
			fast_blanking_out <= 1'b1;
		end
		else
		begin
			rgb_out <= rgb_next;
			fast_blanking_out <= fb_next;
		end
	end
endmodule // osdc_control
`default_nettype wire

// >>> verif/osdc_props.sv
// Purpose: checker for osdc_control
// Assumes: register shadows rebuilt from the write port
// Notes: sync checks hold three edges after reset release
`timescale 1ns/100ps
`default_nettype none
module osdc_props (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic hsync_pin,
	input wire logic vsync_pin,
	input wire logic space_first,
	input wire logic [2:0] work_colour,
	input wire logic split_space_en,
	input wire logic space_transparent,
	input wire logic mesh_en,
	input wire logic blink_phase,
	input wire logic hsync_corrected,
	input wire logic vsync_corrected,
	input wire logic [2:0] rgb_out,
	input wire logic fast_blanking_out
);
	logic [7:0] def_q;
	logic [7:0] ctl_q;
	logic [5:0] vs_n;
	logic [2:0] wd_col;
	logic [1:0] wd_top;
	assign wd_col = sfr_wdata[7:5];
	assign wd_top = sfr_wdata[7:6];
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	sequence vs_edge;
		$rose(vsync_corrected);
	endsequence
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
		begin
			def_q <= 8'h22;
			ctl_q <= 8'h00;
			vs_n <= 6'h00;
		end
		else
		begin
			if (sfr_wr && sfr_addr == 8'h9c)
				def_q <= sfr_wdata;
			if (sfr_wr && sfr_addr == 8'hc1)
				ctl_q <= sfr_wdata;
			vs_n <= $changed(blink_phase) ? 6'h00
				: vs_n + {5'h00, $rose(vsync_corrected)};
		end
	write_def_a: assert property (sfr_wr && sfr_addr == 8'h9c |=>
		work_colour == $past(wd_col)) else $error("defaults lost");
	ctl_bits_a: assert property (sfr_wr && sfr_addr == 8'hc1 |=>
		{split_space_en, mesh_en} == $past(wd_top))
		else $error("control bits lost");
	space_two_a: assert property (space_transparent == !space_first)
		else $error("second space not clear");
	reload_a: assert property (vs_edge |-> ##[1:2]
		work_colour == def_q[7:5]) else $error("no frame reload");
	off_level_a: assert property (!ctl_q[0] && ctl_q == $past(ctl_q) |->
		{rgb_out, fast_blanking_out} == {4{~ctl_q[2]}})
		else $error("outputs not idle");
	hs_fix_a: assert property ($past(rstn, 3) |->
		hsync_corrected == ($past(hsync_pin, 2) ~^ ctl_q[4]))
		else $error("hsync polarity wrong");
	vs_fix_a: assert property ($past(rstn, 3) |->
		vsync_corrected == ($past(vsync_pin, 2) ~^ ctl_q[3]))
		else $error("vsync polarity wrong");
	blink_rate_a: assert property ($changed(blink_phase) |->
		vs_n == (ctl_q[1] ? 6'd32 : 6'd16)) else $error("blink rate wrong");
endmodule // osdc_props
bind osdc_control osdc_props u_props (.mclk, .rstn, .sfr_addr, .sfr_wdata,
	.sfr_wr, .hsync_pin, .vsync_pin, .space_first, .work_colour,
	.split_space_en, .space_transparent, .mesh_en, .blink_phase,
	.hsync_corrected, .vsync_corrected, .rgb_out, .fast_blanking_out);
`default_nettype wire

// >>> verif/osdc_video_model.sv
// Purpose: video side model, makes both sync pins
// Assumes: 20 clock lines, 12 line frames
// Notes: pins rest inactive between runs
`timescale 1ns/100ps
`default_nettype none
module osdc_video_model (
	input wire logic mclk,
	input wire logic run,
	input wire logic pol,
	output logic hs = 1'b1,
	output logic vs = 1'b1
);
	int px = 0;
	int ln = 0;
	always @(posedge mclk)
	begin
		px <= run ? (px + 1) % 20 : 0;
		ln <= !run ? 0 : (px == 19) ? (ln + 1) % 12 : ln;
		hs <= pol ~^ (run && px < 4);
		vs <= pol ~^ (run && ln == 0 && px > 7);
	end
endmodule // osdc_video_model
`default_nettype wire

// >>> verif/test_osd_control_and_vertical_origin.sv
// Purpose: register and sync tests for osdc_control
// Assumes: 200 MHz mclk, model drives both sync pins
// Notes: a second reset runs the slow blink rate
`timescale 1ns/100ps
`default_nettype none
module test_osd_control_and_vertical_origin;
	logic mclk = 0;
	logic rstn = 0;
	logic wr = 0;
	logic run = 0;
	logic pol = 0;
	logic lcv = 0;
	logic chr = 0;
	logic nb;
	logic [7:0] a = 0;
	logic [7:0] d = 0;
	logic [7:0] lcd = 0;
	wire logic [7:0] rd;
	wire logic [2:0] col, rgb;
	wire logic [1:0] sub;
	wire logic h2, w2, spl, st, msh, blk, win, hc, vc, fb, hs, vs;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;
	osdc_control DUT (.mclk(mclk), .rstn(rstn), .sfr_addr(a), .sfr_wdata(d),
		.sfr_wr(wr), .sfr_rdata(rd), .hsync_pin(hs), .vsync_pin(vs),
		.char_on(chr), .char_rgb(3'h5), .lead_code_valid(lcv),
		.lead_code_defaults(lcd), .space_first(1'b0), .work_colour(col),
		.dot_height_double(h2), .dot_width_double(w2), .work_submode(sub),
		.split_space_en(spl), .space_transparent(st), .mesh_en(msh),
		.blink_phase(blk), .display_window(win), .hsync_corrected(hc),
		.vsync_corrected(vc), .rgb_out(rgb), .fast_blanking_out(fb));
	osdc_video_model u_tv (.mclk(mclk), .run(run), .pol(pol), .hs(hs), .vs(vs));
	initial forever #2.5 mclk = ~mclk;
	task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr_reg(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge mclk);
		a <= ad;
		d <= dt;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask
	task rd_chk(input string nm, input logic [7:0] ad, input logic [7:0] e);
		@(posedge mclk);
		a <= ad;
		#1 chk(nm, rd, e);
	endtask
	task frames(input int n);
		run <= 1'b1;
		repeat (n * 240) @(posedge mclk);
		run <= 1'b0;
		repeat (9) @(posedge mclk);
	endtask
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			finish_test;
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		rd_chk("defaults", 8'h9c, 8'h22);
		chk("colour", col, 8'h01);
		rd_chk("unmapped", 8'h9d, 8'h00);
		wr_reg(8'h9c, 8'hff);
		rd_chk("defaults", 8'h9c, 8'hef);
		chk("size", {w2, h2, col}, 8'h1f);
		for (int i = 0; i < 4; i++)
		begin
			wr_reg(8'h9c, i[7:0]);
			chk("submode", {w2, h2, sub}, i[7:0]);
		end
		wr_reg(8'hc2, 8'hc2);
		rd_chk("origin", 8'hc2, 8'h02);
		lcd <= 8'h44;
		lcv <= 1'b1;
		@(posedge mclk);
		lcv <= 1'b0;
		#1 chk("lead", col, 8'h02);
		$display("test registers done");
		pol <= 1'b1;
		wr_reg(8'hc1, 8'hfd);
		chk("split", {spl, msh, st}, 8'h07);
		nb = ~blk;
		frames(20);
		chk("blink", blk, nb);
		chk("window", win, 8'h01);
		chk("frame blank", fb, 8'h01);
		chr <= 1'b1;
		@(posedge mclk);
		#1 chk("colour out", rgb, 8'h05);
		chr <= 1'b0;
		$display("test fast blink done");
		wr_reg(8'hc1, 8'hf8);
		frames(1);
		chk("idle low", {rgb, fb}, 8'h0f);
		wr_reg(8'hc1, 8'hdd);
		frames(1);
		chk("tv blank", fb, 8'h00);
		wr_reg(8'hc1, 8'hdc);
		frames(1);
		chk("idle high", {rgb, fb}, 8'h00);
		$display("test output levels done");
		rstn <= 1'b0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		wr_reg(8'hc1, 8'hff);
		nb = ~blk;
		frames(34);
		chk("blink", blk, nb);
		$display("test slow blink done");
		finish_test;
	end
endmodule // test_osd_control_and_vertical_origin
`default_nettype wire
